/* doh_far_end.sv */
// Far-end overhead source, one bit per bit clock rise.
// Assumes the bench changes pattern and mask only near a marker.
`timescale 1ns/1ps
module doh_far_end (
  input wire logic overhead_bit_clock,
  input wire logic overhead_frame_marker,
  input wire logic [doh_pkg::OH_PER_FRAME-1:0] pattern,
  input wire logic [doh_pkg::OH_PER_FRAME-1:0] mask,
  output logic overhead_serial_in,
  output logic overhead_insert_enable
);
  int k = 0;
  initial begin
    overhead_serial_in = 1'h0;
    overhead_insert_enable = 1'h0;
  end
  // Slot index restarts on the marker, then runs in frame order
  always @(posedge overhead_bit_clock) begin
    k = overhead_frame_marker ? 0 : (k + 1) % doh_pkg::OH_PER_FRAME;
    overhead_serial_in <= pattern[k];
    overhead_insert_enable <= mask[k];
  end
endmodule

/* doh_pkg.sv */
// Constants and carrier types for the transmit overhead insert port.
// Assumes one DS3 frame of 56 overhead slots, each followed by payload bits.
package doh_pkg;
  // Overhead slots in one outbound frame
  localparam int OH_PER_FRAME = 56;
  // Line bits in one outbound frame, default length
  localparam int FRAME_BITS_DEFAULT = 4760;
  // Width of the overhead slot index
  localparam int IDX_W = 6;
  // Width of the bit counter inside one slot group
  localparam int CNT_W = 7;
  // Reset value of all overhead bit stores
  localparam logic [OH_PER_FRAME-1:0] OH_RESET = '0;

  // Serial port outputs that travel together
  typedef struct packed {
    logic bit_clock;
    logic frame_marker;
  } doh_ohport_t;
endpackage

/* doh_sva.sv */
// Checker for the overhead port timing at the top ports.
// Assumes a bind to doh_tx_overhead_port with its FRAME_BITS.
`timescale 1ns/1ps
module doh_sva #(
  parameter int FRAME_BITS = doh_pkg::FRAME_BITS_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic frame_strobe,
  input wire logic line_clk,
  input wire logic payload_in,
  input wire logic payload_ready,
  input wire logic line_data_out,
  input wire logic overhead_bit_clock,
  input wire logic overhead_frame_marker
);
  localparam int BLOCK = FRAME_BITS / doh_pkg::OH_PER_FRAME;
  localparam int HALF = BLOCK / 2;
  localparam int LOW = BLOCK - HALF;
  int hi_n, mk_n, fr_n;
  logic seen;
  // Run lengths of bit clock high, marker high, and frame
  always_ff @(posedge line_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_n <= 0;
      mk_n <= 0;
      fr_n <= 0;
      seen <= 1'h0;
    end else begin
      hi_n <= overhead_bit_clock ? hi_n + 1 : 0;
      mk_n <= overhead_frame_marker ? mk_n + 1 : 0;
      fr_n <= (overhead_frame_marker && mk_n == 0) ? 1 : fr_n + 1;
      seen <= seen | overhead_frame_marker;
    end
  end
  a_clk_high_len: assert property (@(posedge line_clk) disable iff (!reset_n)
    $fell(overhead_bit_clock) |-> hi_n == HALF) else $error("bit clock high length");
  a_clk_low_len: assert property (@(posedge line_clk) disable iff (!reset_n)
    $fell(overhead_bit_clock) |-> ##LOW $rose(overhead_bit_clock)) else $error("bit clock low");
  a_mark_len: assert property (@(posedge line_clk) disable iff (!reset_n)
    $fell(overhead_frame_marker) |-> mk_n == BLOCK) else $error("marker length");
  a_mark_period: assert property (@(posedge line_clk) disable iff (!reset_n)
    $rose(overhead_frame_marker) && seen |-> fr_n == FRAME_BITS) else $error("marker period");
  a_mark_on_fall: assert property (@(posedge line_clk) disable iff (!reset_n)
    $rose(overhead_frame_marker) |-> $fell(overhead_bit_clock)) else $error("marker phase");
  a_mark_sees_rise: assert property (@(posedge line_clk) disable iff (!reset_n)
    $rose(overhead_frame_marker) |-> ##LOW ($rose(overhead_bit_clock) && overhead_frame_marker))
    else $error("marker misses rise");
  a_slot_rate: assert property (@(posedge line_clk) disable iff (!reset_n)
    $fell(payload_ready) |-> ##BLOCK $fell(payload_ready)) else $error("slot spacing");
  a_strobe_once: assert property (@(posedge core_clk) disable iff (!reset_n)
    frame_strobe |=> !frame_strobe) else $error("strobe too long");
  a_payload_pass: assert property (@(posedge line_clk) disable iff (!reset_n)
    $past(payload_ready) |-> line_data_out == $past(payload_in)) else $error("payload bit lost");
endmodule
bind doh_tx_overhead_port doh_sva #(.FRAME_BITS(FRAME_BITS)) doh_sva_inst (.core_clk, .reset_n,
  .frame_strobe, .line_clk, .payload_in, .payload_ready, .line_data_out, .overhead_bit_clock,
  .overhead_frame_marker);

/* doh_sync2.sv */
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes its inputs are levels that stay put for several destination cycles.
`timescale 1ns/1ps
module doh_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  // Two stages, cleared by the asynchronous reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* doh_tx_overhead_port.sv */
// Transmit overhead insert port of a DS3 framer, with outbound frame timing.
// Assumes line_clk is the transmit line clock and runs freely; the core side
// supplies default overhead bits and sees one strobe per outbound frame.
`timescale 1ns/1ps
// Operation
// - Capture serial input at bit clock fall when enabled
// - Ignore serial input while insert enable low
// - Captured bit goes into next outbound frame
// - Frame marker high one bit period per frame
// - Same behaviour in clear channel and ATM
// - Insert enable selects source per overhead bit
module doh_tx_overhead_port #(
  parameter int FRAME_BITS = doh_pkg::FRAME_BITS_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [doh_pkg::OH_PER_FRAME-1:0] internal_overhead,
  output logic frame_strobe,
  input wire logic line_clk,
  input wire logic payload_in,
  output logic payload_ready,
  output logic line_data_out,
  input wire logic overhead_serial_in,
  input wire logic overhead_insert_enable,
  output logic overhead_bit_clock,
  output logic overhead_frame_marker
);
  // Line bits per overhead slot group, and the bit clock half period
  localparam int BLOCK = FRAME_BITS / doh_pkg::OH_PER_FRAME;
  localparam int HALF = BLOCK / 2;
  localparam logic [doh_pkg::CNT_W-1:0] CNT_LAST = doh_pkg::CNT_W'(BLOCK - 1);
  localparam logic [doh_pkg::CNT_W-1:0] CNT_HALF = doh_pkg::CNT_W'(HALF);
  localparam logic [doh_pkg::CNT_W-1:0] CNT_OH = '0;
  localparam logic [doh_pkg::IDX_W-1:0] IDX_LAST = doh_pkg::IDX_W'(doh_pkg::OH_PER_FRAME - 1);
  localparam logic [doh_pkg::IDX_W-1:0] IDX_FIRST = '0;

  // Reset release, synchronised to the line clock
  logic [0:0] link_rst_sync;
  logic link_rst_n;
  // Pin inputs after two flip-flops
  logic [1:0] pin_sync;
  logic ser_s;
  logic ins_s;
  // Position inside the outbound frame
  logic [doh_pkg::CNT_W-1:0] cnt;
  logic [doh_pkg::IDX_W-1:0] idx;
  logic frame_end;
  // Registered port outputs
  doh_pkg::doh_ohport_t port;
  doh_pkg::doh_ohport_t next_port;
  // Marker armed once the first whole frame has run
  logic marker_live;
  // Falling edge of the driven bit clock
  logic capture_now;
  // Bits captured during this frame, and their enable marks
  logic [doh_pkg::OH_PER_FRAME-1:0] cap_bit;
  logic [doh_pkg::OH_PER_FRAME-1:0] cap_mask;
  // Bits in use for the frame going out now
  logic [doh_pkg::OH_PER_FRAME-1:0] act_bit;
  logic [doh_pkg::OH_PER_FRAME-1:0] act_mask;
  logic [doh_pkg::OH_PER_FRAME-1:0] act_int;
  // Frame event toggle, line side
  logic frame_tgl;
  // Core side crossing state
  logic [0:0] tgl_core;
  logic tgl_seen;
  logic [doh_pkg::OH_PER_FRAME-1:0] int_hold;

  // Line side reset release
  doh_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(line_clk),
    .reset_n(reset_n),
    .d(1'b1),
    .q(link_rst_sync)
  );
  assign link_rst_n = link_rst_sync[0];

  // Serial data and insert enable cross from the pins
  doh_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk(line_clk),
    .reset_n(link_rst_n),
    .d({overhead_serial_in, overhead_insert_enable}),
    .q(pin_sync)
  );
  assign ser_s = pin_sync[1];
  assign ins_s = pin_sync[0];

  assign frame_end = (idx == IDX_LAST) && (cnt == CNT_LAST);

  // Bit counter inside a slot group, and the slot index
  always_ff @(posedge line_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt <= '0;
      idx <= '0;
    end else if (cnt == CNT_LAST) begin
      // Group done, step to the next slot
      cnt <= '0;
      idx <= (idx == IDX_LAST) ? IDX_FIRST : idx + 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // Arms the slot 0 half of the marker after the first frame end, so that
  // no short marker leaves the port just after reset
  always_ff @(posedge line_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      marker_live <= 1'b0;
    end else if (frame_end) begin
      marker_live <= 1'b1;
    end
  end

  // Bit clock high in the first half of each group; the same timing is used
  // in clear channel and ATM modes, so no mode term appears
  always_comb begin
    next_port.bit_clock = (cnt < CNT_HALF);
    // Marker spans one full bit clock period around the first rising edge
    next_port.frame_marker = ((idx == IDX_LAST) && (cnt >= CNT_HALF))
      || ((idx == IDX_FIRST) && (cnt < CNT_HALF) && marker_live);
  end

  // Port output registers
  always_ff @(posedge line_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      port <= '0;
    end else begin
      port <= next_port;
    end
  end
  assign overhead_bit_clock = port.bit_clock;
  assign overhead_frame_marker = port.frame_marker;

  // Driven clock is high now and goes low at this edge
  assign capture_now = port.bit_clock && !next_port.bit_clock;

  // One capture cell per overhead slot
  genvar g;
  generate
    for (g = 0; g < doh_pkg::OH_PER_FRAME; g++) begin : g_cap
      always_ff @(posedge line_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
          cap_bit[g] <= 1'b0;
          cap_mask[g] <= 1'b0;
        end else if (capture_now && ins_s && (idx == IDX_LAST - doh_pkg::IDX_W'(
            doh_pkg::OH_PER_FRAME - 1 - g))) begin
          // Enabled slot: take the bit and mark it external
          cap_bit[g] <= ser_s;
          cap_mask[g] <= 1'b1;
        end else if (frame_end) begin
          // Handed over; next frame starts unmarked
          cap_mask[g] <= 1'b0;
        end
        // Disabled slots keep no trace of the serial input
      end
    end
  endgenerate

  // Frame boundary: captured bits become the next frame's overhead
  always_ff @(posedge line_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      act_bit <= doh_pkg::OH_RESET;
      act_mask <= doh_pkg::OH_RESET;
      act_int <= doh_pkg::OH_RESET;
    end else if (frame_end) begin
      act_bit <= cap_bit;
      act_mask <= cap_mask;
      // Core hold register has been stable for most of a frame here
      act_int <= int_hold;
    end
  end

  // Outbound line bit: overhead slot first, then payload
  always_ff @(posedge line_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      line_data_out <= 1'b0;
    end else if (cnt == CNT_OH) begin
      // External bit only where it was enabled
      line_data_out <= act_mask[idx] ? act_bit[idx] : act_int[idx];
    end else begin
      line_data_out <= payload_in;
    end
  end
  // Payload taken on every non overhead bit
  assign payload_ready = (cnt != CNT_OH);

  // Frame event toggle for the core side
  always_ff @(posedge line_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frame_tgl <= 1'b0;
    end else if (frame_end) begin
      frame_tgl <= ~frame_tgl;
    end
  end

  // Toggle crosses into the core clock
  doh_sync2 #(.WIDTH(1)) u_tgl_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .d(frame_tgl),
    .q(tgl_core)
  );

  // Core side edge detect, strobe and default overhead hold
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_seen <= 1'b0;
      frame_strobe <= 1'b0;
      int_hold <= doh_pkg::OH_RESET;
    end else begin
      tgl_seen <= tgl_core[0];
      frame_strobe <= tgl_core[0] ^ tgl_seen;
      if (tgl_core[0] ^ tgl_seen) begin
        // New frame begun; load defaults for the one after it
        int_hold <= internal_overhead;
      end
    end
  end
endmodule

/* tb_top.sv */
// Bench: far-end model feeds the port, outbound overhead checked per slot.
// Assumes FRAME_BITS of 560, ten line cycles per overhead slot.
`timescale 1ns/1ps
module tb_top;
  typedef logic [doh_pkg::OH_PER_FRAME-1:0] doh_oh_t;
  doh_oh_t intl = '0, pat = '0, mask = '0, obs, last;
  logic core_clk = 1'h0, line_clk = 1'h0, reset_n = 1'h0, payload_in = 1'h0, pend = 1'h0;
  logic serial, ins_en, frame_strobe, ready, ldo, bclk, mark;
  int failures = 0, compares = 0, nframes = 0, slot = 0, cyc = 0;
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #7;
    forever #15 line_clk = ~line_clk;
  end
  doh_tx_overhead_port #(.FRAME_BITS(560)) doh_tx_overhead_port_inst (.core_clk(core_clk),
    .reset_n(reset_n), .internal_overhead(intl), .frame_strobe(frame_strobe),
    .line_clk(line_clk), .payload_in(payload_in), .payload_ready(ready), .line_data_out(ldo),
    .overhead_serial_in(serial), .overhead_insert_enable(ins_en),
    .overhead_bit_clock(bclk), .overhead_frame_marker(mark));
  doh_far_end doh_far_end_inst (.overhead_bit_clock(bclk), .overhead_frame_marker(mark),
    .pattern(pat), .mask(mask), .overhead_serial_in(serial), .overhead_insert_enable(ins_en));
  always @(posedge line_clk) payload_in <= #2 ~payload_in;
  // Collect the overhead bit sent after each overhead slot
  always @(posedge line_clk) begin
    if (pend) begin
      obs[slot] = ldo;
      if (slot == 55) begin
        last = obs;
        nframes++;
      end
    end
    pend = !ready && reset_n;
    if (pend) slot = mark ? 0 : (slot + 1) % 56;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      failures++;
      results();
    end
  end
  task automatic check(input string nm, input doh_oh_t seen, input doh_oh_t exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = nframes + n;
    while (nframes < t) @(posedge core_clk);
  endtask
  // New source values at a marker; old, next and later frames judged
  task automatic run(input doh_oh_t p, input doh_oh_t m, input doh_oh_t i);
    doh_oh_t op, om;
    wait_frames(1);
    @(posedge mark);
    @(posedge core_clk);
    #2;
    op = pat;
    om = mask;
    pat = p;
    mask = m;
    intl = i;
    wait_frames(1);
    check("kept", last & m & om, op & m & om);
    wait_frames(1);
    check("inserted", last & m, p & m);
    wait_frames(1);
    check("frame", last, (p & m) | (i & ~m));
  endtask
  task automatic t_internal();
    run(56'hFF_FFFF_0000_0000, '0, 56'h12_3456_789A_BCDE);
  endtask
  task automatic t_external();
    run(56'hA5_C3F0_0F3C_965A, '1, 56'h00_0000_0000_0000);
  endtask
  task automatic t_mixed();
    run(56'h0F_0F0F_F0F0_F0F0, 56'h55_5555_5555_5555, 56'hC3_3C3C_C3C3_3C3C);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #2;
    reset_n = 1'h1;
    t_internal();
    t_external();
    t_mixed();
    results();
  end
endmodule
